//--- include/dsau_pkg.sv
// Package with constants and carrier types for the data-space access unit.
package dsau_pkg;
    // Address space geometry.
    localparam int unsigned EA_W = 16;
    localparam int unsigned PAGE_W = 8;
    localparam int unsigned XADDR_W = 24;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned NEAR_W = 13;
    // Region bounds as byte addresses.
    localparam logic [15:0] CTRL_LAST = 16'h0fff;
    localparam logic [15:0] RAM_FIRST = 16'h1000;
    localparam logic [15:0] IMPL_LAST = 16'hcfff;
    localparam logic [15:0] NEAR_LAST = 16'h1fff;
    // Number of RAM words behind the control region (48 Kbytes).
    localparam int unsigned RAM_WORDS = 24576;
    localparam int unsigned RAM_AW = 15;
    // Post-increment steps.
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    // Reset values.
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [7:0] PAGE_RST = 8'h00;

    // Read request from the read address generator.
    typedef struct packed {
        logic valid;
        logic is_byte;
        logic near_mode;
        logic [15:0] ea;
        logic [7:0] page;
    } dsau_rd_req_t;

    // Write request from the write address generator.
    typedef struct packed {
        logic valid;
        logic is_byte;
        logic near_mode;
        logic [15:0] ea;
        logic [7:0] page;
        logic [15:0] data;
    } dsau_wr_req_t;

    // Working-register operation request.
    typedef enum logic [3:0] {
        WOP_NONE = 4'h1,
        WOP_LOAD_BYTE = 4'h2,
        WOP_SIGN_EXT = 4'h4,
        WOP_ZERO_EXT = 4'h8
    } dsau_wop_t;

    // Whole registered state of the unit.
    typedef struct packed {
        logic [15:0] rd_data;
        logic rd_valid;
        logic [23:0] rd_xaddr;
        logic [23:0] wr_xaddr;
        logic [15:0] ptr_next;
        logic [15:0] wreg_out;
        logic addr_err;
    } dsau_state_t;
endpackage : dsau_pkg

//--- src/dsau_core.sv
// Data-space access unit: decode, byte steering, write lanes and address error trap.
//
// Operation
// [R1] Every effective address is a 16-bit byte address covering 64 Kbytes.
// [R2] Read page joins read address, write page joins write address: 24-bit space.
// [R3] Implemented memory is 4 Kbytes control region plus 48 Kbytes RAM.
// [R4] Accesses beyond implemented memory read back as zero.
// [R5] Low byte of a word sits at the even address, high byte odd.
// [R6] Post-increment pointer steps by one for bytes, two for words.
// [R7] Byte reads fetch the word, pick by address bit zero, deliver low lane.
// [R8] Byte writes strobe only the addressed lane.
// [R9] Read and write addresses arrive from separate generators.
// [R10] Odd address on a word access raises an address error trap.
// [R11] Misaligned read completes; misaligned write is suppressed; trap follows.
// [R12] Byte load into a working register keeps its high byte.
// [R13] Sign extension turns signed 8-bit into signed 16-bit.
// [R14] Zero extension clears the high byte of a working register.
// [R15] Addresses 0x0000 to 0x0fff form the control-register region.
// [R16] Unused control-region reads return zero with no side effect.
// [R17] Direct instructions use 13-bit near addresses; moves use 16-bit.
// [R18] Address error is a one-cycle pulse with the access, cleared by reset; here addr_err pulses in the cycle after the access.
`timescale 1ns/100ps
module dsau_core (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Read address generator port.
    input wire dsau_pkg::dsau_rd_req_t rd_req,
    // Write address generator port.
    input wire dsau_pkg::dsau_wr_req_t wr_req,
    // Pointer post-increment request.
    input wire logic [15:0] ptr_in,
    input wire logic ptr_is_byte,
    // Working-register operation.
    input wire dsau_pkg::dsau_wop_t wop,
    input wire logic [15:0] wreg_in,
    input wire logic [7:0] wop_byte,
    // Control-register region interface to core and peripherals.
    input wire logic [15:0] ctrl_rdata,
    input wire logic ctrl_hit,
    output logic [15:0] ctrl_addr,
    output logic [1:0] ctrl_we,
    output logic [15:0] ctrl_wdata,
    // Read results.
    output logic [15:0] rd_data,
    output logic rd_valid,
    output logic [23:0] rd_xaddr,
    output logic [23:0] wr_xaddr,
    // Working-register and pointer results.
    output logic [15:0] ptr_next,
    output logic [15:0] wreg_out,
    // Exception request.
    output logic addr_err
);
    // Two byte-wide RAM lanes sharing one word address.
    logic [7:0] ram_lo [0:dsau_pkg::RAM_WORDS-1];
    logic [7:0] ram_hi [0:dsau_pkg::RAM_WORDS-1];

    dsau_pkg::dsau_state_t st_r;
    dsau_pkg::dsau_state_t st_nxt;

    logic [15:0] rd_ea;
    logic [15:0] wr_ea;
    logic rd_in_ctrl;
    logic rd_in_ram;
    logic wr_in_ctrl;
    logic wr_in_ram;
    logic rd_misalign;
    logic wr_misalign;
    logic [1:0] wr_lanes;
    logic [15:0] wr_word;
    logic [14:0] rd_widx;
    logic [14:0] wr_widx;
    logic [15:0] ram_word;
    logic [15:0] fetched;
    logic [15:0] rd_off;
    logic [15:0] wr_off;

    // Near-mode accesses carry only a 13-bit field, so the upper bits are forced clear.
    always_comb begin
        rd_ea = rd_req.near_mode ? {3'h0, rd_req.ea[12:0]} : rd_req.ea; // R17
        wr_ea = wr_req.near_mode ? {3'h0, wr_req.ea[12:0]} : wr_req.ea; // R17
    end

    // Region decode on the full 16-bit byte address.
    always_comb begin
        rd_in_ctrl = rd_ea <= dsau_pkg::CTRL_LAST; // R15
        wr_in_ctrl = wr_ea <= dsau_pkg::CTRL_LAST; // R15
        rd_in_ram = (rd_ea >= dsau_pkg::RAM_FIRST) && (rd_ea <= dsau_pkg::IMPL_LAST); // R3
        wr_in_ram = (wr_ea >= dsau_pkg::RAM_FIRST) && (wr_ea <= dsau_pkg::IMPL_LAST); // R3
        rd_off = rd_ea - dsau_pkg::RAM_FIRST;
        wr_off = wr_ea - dsau_pkg::RAM_FIRST;
        rd_widx = rd_off[15:1]; // R1
        wr_widx = wr_off[15:1];
    end

    // Word accesses at odd addresses are faults.
    always_comb begin
        rd_misalign = rd_req.valid && !rd_req.is_byte && rd_ea[0]; // R10
        wr_misalign = wr_req.valid && !wr_req.is_byte && wr_ea[0]; // R10
    end

    // Lane strobes; a faulting write gets none so memory is left untouched.
    always_comb begin
        wr_lanes = 2'h0;
        wr_word = wr_req.data;
        if (wr_req.valid && !wr_misalign) begin // R11
            if (wr_req.is_byte) begin
                wr_lanes = wr_ea[0] ? 2'h2 : 2'h1; // R8
                wr_word = {wr_req.data[7:0], wr_req.data[7:0]}; // R5
            end else begin
                wr_lanes = 2'h3;
            end
        end
    end

    // Control region passes through to its owners on the write side.
    always_comb begin
        ctrl_addr = rd_ea;
        ctrl_we = wr_in_ctrl ? wr_lanes : 2'h0; // R8
        ctrl_wdata = wr_word;
        if (|ctrl_we) begin
            ctrl_addr = wr_ea;
        end
    end

    // Separate read and write ports; memory is a synchronous write, async read array.
    always_ff @(posedge clk) begin // R9
        if (wr_in_ram && wr_lanes[0]) begin
            ram_lo[wr_widx] <= wr_word[7:0]; // R5
        end
        if (wr_in_ram && wr_lanes[1]) begin
            ram_hi[wr_widx] <= wr_word[15:8]; // R5
        end
    end

    // Word fetch; anything outside the implemented space reads as zero.
    always_comb begin
        ram_word = rd_in_ram ? {ram_hi[rd_widx], ram_lo[rd_widx]} : dsau_pkg::WORD_ZERO; // R4
        if (rd_in_ctrl) begin
            fetched = ctrl_hit ? ctrl_rdata : dsau_pkg::WORD_ZERO; // R16
        end else begin
            fetched = ram_word; // R4
        end
    end

    // Next-state logic for all registered outputs.
    always_comb begin
        st_nxt = st_r;
        st_nxt.rd_valid = rd_req.valid;
        if (rd_req.valid) begin
            if (rd_req.is_byte) begin
                // The whole word is fetched; bit zero chooses the byte.
                st_nxt.rd_data = {8'h00, rd_ea[0] ? fetched[15:8] : fetched[7:0]}; // R7
            end else begin
                // A misaligned read still completes with the aligned word.
                st_nxt.rd_data = fetched; // R11
            end
            st_nxt.rd_xaddr = {rd_req.page, rd_ea}; // R2
        end
        if (wr_req.valid) begin
            st_nxt.wr_xaddr = {wr_req.page, wr_ea}; // R2
        end
        st_nxt.ptr_next = ptr_in + (ptr_is_byte ? dsau_pkg::STEP_BYTE : dsau_pkg::STEP_WORD); // R6
        unique case (wop)
            dsau_pkg::WOP_LOAD_BYTE: st_nxt.wreg_out = {wreg_in[15:8], wop_byte}; // R12
            dsau_pkg::WOP_SIGN_EXT: st_nxt.wreg_out = {{8{wreg_in[7]}}, wreg_in[7:0]}; // R13
            dsau_pkg::WOP_ZERO_EXT: st_nxt.wreg_out = {8'h00, wreg_in[7:0]}; // R14
            dsau_pkg::WOP_NONE: st_nxt.wreg_out = wreg_in;
            default: st_nxt.wreg_out = wreg_in;
        endcase
        // Pulse lasts exactly the cycle after the faulting access.
        st_nxt.addr_err = rd_misalign || wr_misalign; // R18
    end

    // State register.
    always_ff @(posedge clk) begin
        if (reset) begin
            st_r <= '0; // R18
        end else begin
            st_r <= st_nxt;
        end
    end

    // Read, pointer, register and trap outputs come straight from the state register; the ctrl_ outputs are combinational.
    always_comb begin
        rd_data = st_r.rd_data;
        rd_valid = st_r.rd_valid;
        rd_xaddr = st_r.rd_xaddr;
        wr_xaddr = st_r.wr_xaddr;
        ptr_next = st_r.ptr_next;
        wreg_out = st_r.wreg_out;
        addr_err = st_r.addr_err; // R11
    end
endmodule : dsau_core

//--- tb/dsau_core_properties.sv
// Port checker for the data-space access unit.
`timescale 1ns/100ps
module dsau_core_properties (
    // Watched ports.
    input wire logic clk,
    input wire logic reset,
    input wire dsau_pkg::dsau_rd_req_t rd_req,
    input wire dsau_pkg::dsau_wr_req_t wr_req,
    input wire logic ctrl_hit,
    input wire logic [1:0] ctrl_we,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid,
    input wire logic [23:0] wr_xaddr,
    input wire logic addr_err
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    // Word access at an odd address on either port.
    logic mis;
    assign mis = rd_req.valid && !rd_req.is_byte && rd_req.ea[0]
        || wr_req.valid && !wr_req.is_byte && wr_req.ea[0];
    property p_err; mis |=> addr_err; endproperty
    a_err: assert property (p_err) else $error("no trap");
    property p_cause; addr_err |-> $past(mis); endproperty
    a_cause: assert property (p_cause) else $error("stray trap");
    property p_lane; wr_req.valid && wr_req.is_byte && wr_req.ea < 16'h1000
        |-> ctrl_we == {wr_req.ea[0], !wr_req.ea[0]}; endproperty
    a_lane: assert property (p_lane) else $error("bad lane");
    property p_nowr; wr_req.valid && !wr_req.is_byte && wr_req.ea[0] |-> ctrl_we == 2'h0;
    endproperty
    a_nowr: assert property (p_nowr) else $error("odd write strobed");
    property p_sfr; rd_req.valid && rd_req.ea < 16'h1000 && ctrl_we == 2'h0 && !ctrl_hit
        |=> rd_data == 16'h0000; endproperty
    a_sfr: assert property (p_sfr) else $error("unused not zero");
    property p_hole; rd_req.valid && !rd_req.near_mode && rd_req.ea > 16'hcfff
        |=> rd_data == 16'h0000; endproperty
    a_hole: assert property (p_hole) else $error("hole not zero");
    property p_xa; wr_req.valid && !wr_req.near_mode && !mis
        |=> wr_xaddr == {$past(wr_req.page), $past(wr_req.ea)}; endproperty
    a_xa: assert property (p_xa) else $error("bad write page");
    property p_rdv; rd_req.valid |=> rd_valid; endproperty
    a_rdv: assert property (p_rdv) else $error("no read reply");
    c_err: cover property (addr_err);
    c_lane: cover property (ctrl_we == 2'h2);
    c_near: cover property (rd_req.valid && rd_req.near_mode);
endmodule : dsau_core_properties
bind dsau_core dsau_core_properties dsau_core_properties_inst (.*);

//--- tb/dsau_core_tb.sv
// Self-checking bench for the data-space access unit.
`timescale 1ns/100ps
module dsau_core_tb;
    logic clk, reset, ptr_is_byte, ctrl_hit, rd_valid, addr_err;
    logic [15:0] ptr_in, wreg_in, ctrl_rdata, ctrl_addr, ctrl_wdata;
    logic [15:0] rd_data, ptr_next, wreg_out;
    logic [7:0] wop_byte;
    logic [1:0] ctrl_we;
    logic [23:0] rd_xaddr, wr_xaddr;
    dsau_pkg::dsau_rd_req_t rd_req;
    dsau_pkg::dsau_wr_req_t wr_req;
    dsau_pkg::dsau_wop_t wop;
    int n_fail, n_compared;
    dsau_core dsau_core_inst (.*);
    dsau_ctrl_model dsau_ctrl_model_inst (.*);
    // The 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // A hang counts as a mismatch.
    initial begin
        #20000;
        n_fail++;
        give_verdict();
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %h not %h", $time, got, exp);
        end
    endtask : chk
    // One access; m[1] is near mode, m[0] byte size, d the data or the expected read.
    task automatic acc(input logic w, input logic [15:0] ea, input logic [1:0] m,
        input logic [15:0] d);
        @(posedge clk);
        #1;
        if (w) wr_req = '{1'b1, m[0], m[1], ea, 8'hc3, d};
        else rd_req = '{1'b1, m[0], m[1], ea, 8'h3c};
        @(posedge clk);
        #1;
        rd_req.valid = 1'b0;
        wr_req.valid = 1'b0;
        if (!w) chk(rd_data, d);
        chk({23'h000000, rd_valid}, {23'h000000, !w});
    endtask : acc
    // Pointer step and register operation from one operand, answered an edge later.
    task automatic t_unit(input logic pb, input dsau_pkg::dsau_wop_t op,
        input logic [15:0] w, input logic [7:0] b, input logic [15:0] ep, ew);
        @(posedge clk);
        #1;
        ptr_in = w;
        ptr_is_byte = pb;
        wop = op;
        wreg_in = w;
        wop_byte = b;
        @(posedge clk);
        #1;
        chk(ptr_next, ep);
        chk(wreg_out, ew);
    endtask : t_unit
    // RAM words, lane writes, byte picks and near addressing.
    task automatic t_ram();
        acc(1'b1, 16'h1000, 2'h0, 16'ha55a);
        chk(wr_xaddr, 24'hc31000);
        acc(1'b1, 16'h1001, 2'h1, 16'h003c);
        acc(1'b0, 16'h1000, 2'h0, 16'h3c5a);
        chk(rd_xaddr, 24'h3c1000);
        acc(1'b0, 16'h1001, 2'h1, 16'h003c);
        acc(1'b0, 16'h3000, 2'h2, 16'h3c5a);
    endtask : t_ram
    // Misaligned write is dropped and trapped; misaligned read completes.
    task automatic t_odd();
        acc(1'b1, 16'h1001, 2'h0, 16'hffff);
        chk(addr_err, 1'b1);
        acc(1'b0, 16'h1001, 2'h0, 16'h3c5a);
        chk(addr_err, 1'b1);
        // An aligned byte read right after the fault must see the pulse gone.
        acc(1'b0, 16'h1000, 2'h1, 16'h005a);
        chk(addr_err, 1'b0);
    endtask : t_odd
    // Control region, an unused control address and the hole above RAM.
    task automatic t_map();
        acc(1'b1, 16'h0801, 2'h1, 16'h0077);
        acc(1'b0, 16'h0800, 2'h0, 16'h7700);
        acc(1'b0, 16'h0900, 2'h0, 16'h0000);
        acc(1'b0, 16'hd000, 2'h0, 16'h0000);
    endtask : t_map
    task automatic give_verdict();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    // Reset for eight cycles, then the scenarios.
    initial begin
        reset = 1'b1;
        rd_req = '0;
        wr_req = '0;
        ptr_in = 16'h0000;
        ptr_is_byte = 1'b0;
        wop = dsau_pkg::WOP_NONE;
        wreg_in = 16'h0000;
        wop_byte = 8'h00;
        n_fail = 0;
        n_compared = 0;
        repeat (8) @(posedge clk);
        #1 reset = 1'b0;
        // Registered outputs must come out of reset cleared.
        chk(rd_valid, 1'b0);
        chk(addr_err, 1'b0);
        chk(rd_data, 16'h0000);
        t_ram();
        t_odd();
        t_map();
        t_unit(1'b0, dsau_pkg::WOP_LOAD_BYTE, 16'hfffe, 8'h80, 16'h0000, 16'hff80);
        t_unit(1'b1, dsau_pkg::WOP_SIGN_EXT, 16'h1285, 8'h85, 16'h1286, 16'hff85);
        t_unit(1'b1, dsau_pkg::WOP_ZERO_EXT, 16'hab7f, 8'h7f, 16'hab80, 16'h007f);
        give_verdict();
    end
endmodule : dsau_core_tb

//--- tb/dsau_ctrl_model.sv
// Stand-in for the core and peripheral control registers.
`timescale 1ns/100ps
module dsau_ctrl_model (
    // Clock, reset and control-region bus.
    input wire logic clk,
    input wire logic reset,
    input wire logic [15:0] ctrl_addr,
    input wire logic [1:0] ctrl_we,
    input wire logic [15:0] ctrl_wdata,
    output logic [15:0] ctrl_rdata,
    output logic ctrl_hit
);
    logic [15:0] word_r;
    // One word at 0x0800; misses show an inverted pattern so zeroing is proven.
    assign ctrl_hit = ctrl_addr[15:1] == 15'h0400;
    assign ctrl_rdata = ctrl_hit ? word_r : ~word_r;
    // Each strobe writes only its own lane.
    always_ff @(posedge clk) begin
        if (reset) word_r <= 16'h0000;
        if (!reset && ctrl_we[0]) word_r[7:0] <= ctrl_wdata[7:0];
        if (!reset && ctrl_we[1]) word_r[15:8] <= ctrl_wdata[15:8];
    end
endmodule : dsau_ctrl_model
